// ==== rtl/rtbe_regs.svh ====
`ifndef RTBE_REGS_SVH
`define RTBE_REGS_SVH
// 125 MHz core clock
`define RTBE_CLK_HZ          125000000
`define RTBE_TICK_HZ         1000
`define RTBE_TICK_DIV        (`RTBE_CLK_HZ / `RTBE_TICK_HZ)
`define RTBE_TICKS_NOMINAL   1000
`define RTBE_TICKS_SHORT     999
`define RTBE_TICKS_LONG      1001
`define RTBE_MS_PER_WEEK     604800000
`define RTBE_NS_PER_MS       1000000
`define RTBE_NS_PER_CS       10000000
`define RTBE_NS_HALF_CS      5000000
`define RTBE_DEFAULT_LEAP_S  18
`define RTBE_UTC_PARAM_MIN   12.5
`define RTBE_EPOCH_YEAR      1980
`define RTBE_EPOCH_DOY       5
`endif

// ==== rtl/rtbe_pkg.sv ====
package rtbe_pkg;
  typedef struct packed {
    logic [15:0] year;
    logic [3:0]  month;
    logic [4:0]  day;
    logic [4:0]  hour;
    logic [5:0]  minute;
    logic [5:0]  second;
    logic signed [31:0] nano;
  } rtbe_utc_type;

  typedef struct packed {
    logic date_known_flag;
    logic time_known_flag;
    logic date_confirmed_flag;
    logic time_confirmed_flag;
    logic confirmation_available_bit;
    logic whole_second_resolved_flag;
  } rtbe_valid_type;

  typedef struct packed {
    logic [15:0] week;
    logic [31:0] tow_ms;
  } rtbe_gtime_type;

  typedef enum logic [1:0] {
    RTBE_SRC_NONE,
    RTBE_SRC_SAT,
    RTBE_SRC_AID
  } rtbe_src_type;

  typedef enum {
    RTBE_IDLE,
    RTBE_DAYS,
    RTBE_YEAR,
    RTBE_MONTH,
    RTBE_DONE
  } rtbe_conv_type;
endpackage : rtbe_pkg

// ==== rtl/rtbe_time_base.sv ====
`timescale 1ns/100ps
`include "rtbe_regs.svh"
// Function
// - Divide core clock to a 1 kHz reference tick
// - Measurement strobe coincides with reference tick edges
// - Before time is known, local time counts elapsed ms ticks
// - Credible time input steps local time to system time
// - Epoch begins on the tick nearest the desired solution time
// - 1000 ticks per epoch normally, 999 or 1001 to remove drift
// - Bias is solved time minus local time; drift is its change
// - Each solved time arriving while the sequencer is in RTBE_IDLE is converted to GPS time and UTC
// - Conversion parameters accepted from broadcast or host aiding
// - Without parameters use default offset; flag time invalid
// - All outputs of one solution carry its epoch GPS stamp
// - Priority mode: stamp valid only within its message group
// - Time held as week count since 1980 plus ms of week
// - Date and time known flags only when actually known
// - Confirmed flags only after independent confirmation
// - Resolved flag when leap-second count is known or GLONASS is the time base
// - NMEA UTC rounded to hundredths, two fraction digits
// - Compat setting prints three digits, last digit zero
// - Binary UTC fields equal the rounded NMEA fields
// - Nano field is true time minus rounded fields
// - Negative nano carries round-up through all date fields
// - Host selects reported UTC variant
module rtbe_time_base #(
  parameter int unsigned TICK_DIV   = `RTBE_TICK_DIV,
  parameter int unsigned EPOCH_MS   = `RTBE_TICKS_NOMINAL,
  parameter int unsigned GROUP_BITS = 2
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  time_set_i,
  input  wire rtbe_pkg::rtbe_src_type time_src_i,
  input  wire rtbe_pkg::rtbe_gtime_type time_set_val_i,
  input  wire logic                  date_known_i,
  input  wire logic                  solution_i,
  input  wire rtbe_pkg::rtbe_gtime_type solved_time_i,
  input  wire logic [19:0]           solved_sub_ns_i,
  input  wire logic                  utc_param_i,
  input  wire logic                  utc_param_aid_i,
  input  wire logic signed [7:0]     leap_s_i,
  input  wire logic                  glonass_base_i,
  input  wire logic                  confirm_avail_i,
  input  wire logic                  confirm_date_i,
  input  wire logic                  confirm_time_i,
  input  wire logic                  priority_nav_i,
  input  wire logic [GROUP_BITS-1:0] group_i,
  input  wire logic                  nmea_compat_setting_i,
  input  wire logic [2:0]            utc_variant_select_i,
  output logic                       tick_o,
  output logic                       meas_strobe_o,
  output logic                       epoch_o,
  output logic [31:0]                local_ms_o,
  output logic [15:0]                local_week_o,
  output logic signed [31:0]         clock_bias_ms_o,
  output logic signed [31:0]         clock_drift_ms_o,
  output logic [31:0]                epoch_gps_week_time_stamp_o,
  output logic [GROUP_BITS-1:0]      stamp_group_o,
  output rtbe_pkg::rtbe_gtime_type   gps_time_o,
  output rtbe_pkg::rtbe_utc_type     utc_o,
  output rtbe_pkg::rtbe_valid_type   valid_o,
  output logic [1:0]                 nmea_frac_digits_o,
  output logic [9:0]                 nmea_frac_o,
  output logic [2:0]                 utc_variant_o,
  output logic                       report_o
);
  localparam logic [31:0] WEEK_MS = 32'(`RTBE_MS_PER_WEEK);

  function automatic logic leap_year(input logic [15:0] y);
    leap_year = (y[1:0] == 2'h0);
  endfunction : leap_year

  function automatic logic [4:0] month_days(input logic [3:0] m,
                                             input logic [15:0] y);
    unique case (m)
      4'h2:                      month_days = leap_year(y) ? 5'h1D : 5'h1C;
      4'h4, 4'h6, 4'h9, 4'hB:    month_days = 5'h1E;
      default:                   month_days = 5'h1F;
    endcase
  endfunction : month_days

  logic [$clog2(TICK_DIV)-1:0] div_r;
  logic        tick_r;
  logic [10:0] ep_cnt_r;
  logic [10:0] ep_len_r;
  logic [31:0] local_ms_r;
  logic [15:0] local_week_r;
  logic        time_known_r;
  logic        params_r;
  logic signed [31:0] bias_r;
  logic signed [31:0] prev_bias_r;

  // Free-running divider; oscillator nominal value lives in TICK_DIV
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == $bits(div_r)'(TICK_DIV - 1));
      if (div_r == $bits(div_r)'(TICK_DIV - 1))
        div_r <= '0;
      else
        div_r <= div_r + 1'b1;
    end
  end
  assign tick_o        = tick_r;
  assign meas_strobe_o = tick_r;

  // Local time: elapsed ms until stepped to system time
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      local_ms_r   <= '0;
      local_week_r <= '0;
      time_known_r <= 1'b0;
    end else if (time_set_i && time_src_i != rtbe_pkg::RTBE_SRC_NONE) begin
      local_ms_r   <= time_set_val_i.tow_ms;
      local_week_r <= time_set_val_i.week;
      time_known_r <= 1'b1;
    end else if (tick_r) begin
      if (time_known_r && local_ms_r == WEEK_MS - 1) begin
        local_ms_r   <= '0;
        local_week_r <= local_week_r + 1'b1;
      end else begin
        local_ms_r <= local_ms_r + 1'b1;
      end
    end
  end
  assign local_ms_o   = local_ms_r;
  assign local_week_o = local_week_r;

  // Epoch spacing trimmed by one tick when bias exceeds half a tick
  logic signed [31:0] bias_nxt;
  assign bias_nxt = $signed(solved_time_i.tow_ms) - $signed(local_ms_r);
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ep_cnt_r    <= '0;
      ep_len_r    <= 11'(EPOCH_MS);
      bias_r      <= '0;
      prev_bias_r <= '0;
    end else begin
      if (tick_r) begin
        // At or beyond end: a shortened length must not strand the count
        if (ep_cnt_r >= ep_len_r - 1'b1) begin
          ep_cnt_r <= '0;
          ep_len_r <= 11'(EPOCH_MS);
        end else begin
          ep_cnt_r <= ep_cnt_r + 1'b1;
        end
      end
      if (solution_i) begin
        bias_r      <= bias_nxt;
        prev_bias_r <= bias_r;
        // Nearest tick: any nonzero whole-ms bias shifts the epoch one tick
        if (bias_nxt > 0)
          ep_len_r <= 11'(EPOCH_MS + 1);
        else if (bias_nxt < 0)
          ep_len_r <= 11'(EPOCH_MS - 1);
        else
          ep_len_r <= 11'(EPOCH_MS);
      end
    end
  end
  assign epoch_o          = tick_r && (ep_cnt_r >= ep_len_r - 1'b1);
  assign clock_bias_ms_o  = bias_r;
  assign clock_drift_ms_o = bias_r - prev_bias_r;

  // Conversion parameters: broadcast or host aiding
  logic signed [7:0] leap_r;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      params_r <= 1'b0;
      leap_r   <= 8'sd`RTBE_DEFAULT_LEAP_S;
    end else if (utc_param_i || utc_param_aid_i) begin
      params_r <= 1'b1;
      leap_r   <= leap_s_i;
    end
  end

  // UTC conversion sequencer: one date field per step keeps logic small
  rtbe_pkg::rtbe_conv_type st_r;
  logic [31:0] utc_ms_r;
  logic [19:0] sub_r;
  logic [31:0] days_r;
  logic [15:0] yr_r;
  logic [3:0]  mo_r;
  logic [4:0]  dy_r;
  logic [31:0] ms_day_r;
  logic signed [31:0] nano_r;
  // Signed so a time just after week start borrows from the day before
  logic signed [32:0] adj_ms;
  assign adj_ms = $signed({1'b0, solved_time_i.tow_ms})
                  - 33'(leap_r) * 33'sd1000;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r      <= rtbe_pkg::RTBE_IDLE;
      utc_ms_r  <= '0;
      sub_r     <= '0;
      days_r    <= '0;
      yr_r      <= 16'(`RTBE_EPOCH_YEAR);
      mo_r      <= 4'h1;
      dy_r      <= 5'h1;
      ms_day_r  <= '0;
      nano_r    <= '0;
      report_o  <= 1'b0;
      gps_time_o <= '0;
      epoch_gps_week_time_stamp_o <= '0;
      stamp_group_o <= '0;
    end else begin
      report_o <= 1'b0;
      unique case (st_r)
        rtbe_pkg::RTBE_IDLE: if (solution_i) begin
          gps_time_o <= solved_time_i;
          epoch_gps_week_time_stamp_o <= solved_time_i.tow_ms;
          stamp_group_o <= priority_nav_i ? group_i : '0;
          // Round to hundredths: sub-ms part and ms below 10 ms
          sub_r <= solved_sub_ns_i;
          nano_r <= 32'(solved_time_i.tow_ms % 10) * `RTBE_NS_PER_MS
                    + 32'(solved_sub_ns_i);
          // Leap seconds subtracted; default offset when unknown
          if (adj_ms < 0) begin
            days_r   <= 32'(solved_time_i.week) * 7 + `RTBE_EPOCH_DOY - 1;
            ms_day_r <= 32'(adj_ms + 33'sd86400000);
          end else begin
            days_r   <= 32'(solved_time_i.week) * 7 + `RTBE_EPOCH_DOY
                        + 32'(adj_ms / 33'sd86400000);
            ms_day_r <= 32'(adj_ms % 33'sd86400000);
          end
          yr_r <= 16'(`RTBE_EPOCH_YEAR);
          mo_r <= 4'h1;
          st_r <= rtbe_pkg::RTBE_DAYS;
        end
        rtbe_pkg::RTBE_DAYS: begin
          // Round up when remainder at or above half a hundredth
          if (nano_r >= `RTBE_NS_HALF_CS) begin
            nano_r <= nano_r - `RTBE_NS_PER_CS;
            if (ms_day_r / 10 == 8639999) begin
              ms_day_r <= '0;
              days_r   <= days_r + 1;
            end else begin
              ms_day_r <= (ms_day_r / 10 + 1) * 10;
            end
          end else begin
            ms_day_r <= (ms_day_r / 10) * 10;
          end
          st_r <= rtbe_pkg::RTBE_YEAR;
        end
        rtbe_pkg::RTBE_YEAR: begin
          if (days_r >= (leap_year(yr_r) ? 366 : 365)) begin
            days_r <= days_r - (leap_year(yr_r) ? 366 : 365);
            yr_r   <= yr_r + 1'b1;
          end else begin
            st_r <= rtbe_pkg::RTBE_MONTH;
          end
        end
        rtbe_pkg::RTBE_MONTH: begin
          if (days_r >= 32'(month_days(mo_r, yr_r))) begin
            days_r <= days_r - 32'(month_days(mo_r, yr_r));
            mo_r   <= mo_r + 1'b1;
          end else begin
            dy_r <= 5'(days_r + 1);
            st_r <= rtbe_pkg::RTBE_DONE;
          end
        end
        rtbe_pkg::RTBE_DONE: begin
          utc_ms_r <= ms_day_r;
          report_o <= 1'b1;
          st_r     <= rtbe_pkg::RTBE_IDLE;
        end
      endcase
    end
  end

  // Binary fields and NMEA text share one rounded value
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      utc_o <= '0;
      nmea_frac_o <= '0;
      nmea_frac_digits_o <= 2'h2;
      utc_variant_o <= '0;
      valid_o <= '0;
    end else if (st_r == rtbe_pkg::RTBE_DONE) begin
      utc_o.year   <= yr_r;
      utc_o.month  <= mo_r;
      utc_o.day    <= dy_r;
      utc_o.hour   <= 5'(ms_day_r / 3600000);
      utc_o.minute <= 6'((ms_day_r / 60000) % 60);
      utc_o.second <= 6'((ms_day_r / 1000) % 60);
      // Hundredths stay in nano: only whole seconds live in the fields
      utc_o.nano   <= nano_r
                      + 32'((ms_day_r % 1000) * `RTBE_NS_PER_MS);
      nmea_frac_o  <= nmea_compat_setting_i ?
                      10'((ms_day_r % 1000) / 10 * 10) :
                      10'((ms_day_r % 1000) / 10);
      nmea_frac_digits_o <= nmea_compat_setting_i ? 2'h3 : 2'h2;
      utc_variant_o <= utc_variant_select_i;
      valid_o.date_known_flag <= time_known_r && date_known_i;
      valid_o.time_known_flag <= time_known_r && params_r;
      valid_o.confirmation_available_bit <= confirm_avail_i;
      valid_o.date_confirmed_flag <= confirm_avail_i && confirm_date_i
                                     && date_known_i;
      valid_o.time_confirmed_flag <= confirm_avail_i && confirm_time_i
                                     && time_known_r;
      valid_o.whole_second_resolved_flag <= params_r || glonass_base_i;
    end
  end
endmodule : rtbe_time_base

// ==== test/rtbe_time_base_checker.sv ====
`timescale 1ns/100ps
module rtbe_time_base_checker #(
  parameter int unsigned TICK_DIV = 10,
  parameter int unsigned EPOCH_MS = 5
) (
  input wire logic                     core_clk_i,
  input wire logic                     reset_i,
  input wire logic                     time_set_i,
  input wire rtbe_pkg::rtbe_src_type   time_src_i,
  input wire rtbe_pkg::rtbe_gtime_type time_set_val_i,
  input wire logic                     solution_i,
  input wire logic                     nmea_compat_setting_i,
  input wire logic                     tick_o,
  input wire logic                     meas_strobe_o,
  input wire logic                     epoch_o,
  input wire logic [31:0]              local_ms_o,
  input wire logic [31:0]              epoch_gps_week_time_stamp_o,
  input wire rtbe_pkg::rtbe_gtime_type gps_time_o,
  input wire rtbe_pkg::rtbe_utc_type   utc_o,
  input wire logic [1:0]               nmea_frac_digits_o,
  input wire logic                     report_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [31:0] gap_r;
  logic [31:0] tks_r;
  logic [15:0] wait_r;
  logic        tk_seen_r;
  logic        ep_seen_r;
  logic        pend_r;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_r     <= 32'h0;
      tk_seen_r <= 1'b0;
    end else begin
      gap_r     <= tick_o ? 32'h0 : gap_r + 32'h1;
      tk_seen_r <= tk_seen_r | tick_o;
    end
  end
  // A step in local time may realign the epoch, so restart the count
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i || time_set_i) begin
      tks_r     <= 32'h0;
      ep_seen_r <= 1'b0;
    end else if (epoch_o) begin
      tks_r     <= 32'h0;
      ep_seen_r <= 1'b1;
    end else if (tick_o) begin
      tks_r <= tks_r + 32'h1;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_r <= 1'b0;
      wait_r <= 16'h0;
    end else begin
      pend_r <= report_o ? 1'b0 : (pend_r | solution_i);
      wait_r <= pend_r ? wait_r + 16'h1 : 16'h0;
    end
  end
  a_strobe_on_tick: assert property (
    meas_strobe_o == tick_o) else $error("strobe off tick");
  a_tick_period: assert property (
    tk_seen_r |-> (tick_o == (gap_r == TICK_DIV - 1)))
    else $error("tick period wrong");
  a_epoch_on_tick: assert property (
    epoch_o |-> tick_o) else $error("epoch off tick");
  a_epoch_spacing: assert property (
    epoch_o && ep_seen_r |-> tks_r >= EPOCH_MS - 2 && tks_r <= EPOCH_MS)
    else $error("epoch spacing wrong");
  a_local_hold: assert property (
    !tick_o && !time_set_i |=> $stable(local_ms_o))
    else $error("local time moved between ticks");
  a_local_count: assert property (
    tick_o && !time_set_i |=> local_ms_o == $past(local_ms_o) + 32'h1)
    else $error("local time missed a tick");
  a_time_step: assert property (
    time_set_i && !tick_o && time_src_i != rtbe_pkg::RTBE_SRC_NONE
    |=> local_ms_o == $past(time_set_val_i.tow_ms))
    else $error("local time not stepped");
  a_stamp_match: assert property (
    report_o |-> epoch_gps_week_time_stamp_o == gps_time_o.tow_ms)
    else $error("stamp differs from gps time");
  a_answer_bound: assert property (
    wait_r < 16'd200) else $error("no report in time");
  a_nano_range: assert property (
    report_o |-> utc_o.nano >= -5000000 && utc_o.nano <= 994999999)
    else $error("nano out of range");
  a_frac_digits: assert property (
    report_o |-> nmea_frac_digits_o == (nmea_compat_setting_i ? 2'h3 : 2'h2))
    else $error("fraction digit count wrong");
endmodule : rtbe_time_base_checker

bind rtbe_time_base rtbe_time_base_checker #(
  .TICK_DIV(TICK_DIV),
  .EPOCH_MS(EPOCH_MS)
) u_chk (
  .core_clk_i(core_clk_i),
  .reset_i(reset_i),
  .time_set_i(time_set_i),
  .time_src_i(time_src_i),
  .time_set_val_i(time_set_val_i),
  .solution_i(solution_i),
  .nmea_compat_setting_i(nmea_compat_setting_i),
  .tick_o(tick_o),
  .meas_strobe_o(meas_strobe_o),
  .epoch_o(epoch_o),
  .local_ms_o(local_ms_o),
  .epoch_gps_week_time_stamp_o(epoch_gps_week_time_stamp_o),
  .gps_time_o(gps_time_o),
  .utc_o(utc_o),
  .nmea_frac_digits_o(nmea_frac_digits_o),
  .report_o(report_o)
);

// ==== test/rtbe_host_model.sv ====
`timescale 1ns/100ps
module rtbe_host_model (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic        report_i,
  input  wire logic [31:0] stamp_i,
  output logic [15:0]      reports_o,
  output logic [31:0]      stamp_copy_o
);
  // Host only reads what is offered in the report cycle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reports_o    <= 16'h0;
      stamp_copy_o <= 32'h0;
    end else if (report_i) begin
      reports_o    <= reports_o + 16'h1;
      stamp_copy_o <= stamp_i;
    end
  end
endmodule : rtbe_host_model

// ==== test/test_receiver_time_base_epoch.sv ====
`timescale 1ns/100ps
module test_receiver_time_base_epoch;
  logic core_clk_i, reset_i, time_set_i, date_known_i, solution_i;
  logic utc_param_i, utc_param_aid_i, glonass_base_i, priority_nav_i;
  logic confirm_avail_i, confirm_date_i, confirm_time_i, report_o;
  logic nmea_compat_setting_i, tick_o, meas_strobe_o, epoch_o;
  logic [1:0]  group_i, stamp_group_o, nmea_frac_digits_o;
  logic [2:0]  utc_variant_select_i, utc_variant_o;
  logic [9:0]  nmea_frac_o;
  logic [15:0] local_week_o, host_n;
  logic [19:0] solved_sub_ns_i;
  logic [31:0] local_ms_o, epoch_gps_week_time_stamp_o, host_stamp;
  logic signed [7:0]  leap_s_i;
  logic signed [31:0] clock_bias_ms_o, clock_drift_ms_o;
  rtbe_pkg::rtbe_src_type   time_src_i;
  rtbe_pkg::rtbe_gtime_type time_set_val_i, solved_time_i, gps_time_o;
  rtbe_pkg::rtbe_utc_type   utc_o;
  rtbe_pkg::rtbe_valid_type valid_o;
  int     mismatches, num_checks, cyc, ticks, epochs, nsol, lp;
  logic   prm;
  integer seed;
  longint ecs;
  rtbe_time_base #(.TICK_DIV(10), .EPOCH_MS(5)) u_dut (.*);
  rtbe_host_model u_host (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .report_i(report_o), .stamp_i(epoch_gps_week_time_stamp_o),
    .reports_o(host_n), .stamp_copy_o(host_stamp));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    ticks <= reset_i ? 0 : ticks + int'(tick_o);
    epochs <= reset_i ? 0 : epochs + int'(epoch_o);
    if (cyc == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_utc(input rtbe_pkg::rtbe_utc_type got,
                         input rtbe_pkg::rtbe_utc_type exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t utc %h expected %h", $time, got, exp);
    end
  endtask : chk_utc
  function automatic rtbe_pkg::rtbe_utc_type exp_utc(input longint w, t,
                                                     input longint s, l);
    rtbe_pkg::rtbe_utc_type u;
    longint ms, ns, sec, d, y, m, dm;
    ms = w * 604800000 + t - l * 1000;
    ns = (ms % 1000) * 1000000 + s;
    ecs = (ns + 5000000) / 10000000;
    u.nano = 32'(ns - (ecs / 100) * 1000000000);
    sec = ms / 1000 + ecs / 100;
    ecs = ecs % 100;
    d = sec / 86400 + 5;
    u.hour = 5'(sec % 86400 / 3600);
    u.minute = 6'(sec % 3600 / 60);
    u.second = 6'(sec % 60);
    for (y = 1980; d >= ((y % 4) ? 365 : 366); y++) d -= (y % 4) ? 365 : 366;
    dm = 31;
    for (m = 1; d >= dm; m++) begin
      d -= dm;
      dm = (m == 1) ? ((y % 4) ? 28 : 29) : (m inside {3, 5, 8, 10}) ? 30 : 31;
    end
    u.year = 16'(y);
    u.month = 4'(m);
    u.day = 5'(d + 1);
    return u;
  endfunction : exp_utc
  task automatic step(input rtbe_pkg::rtbe_src_type src, input logic [31:0] ms);
    logic [31:0] was;
    @(posedge core_clk_i iff tick_o);
    time_set_i <= 1'b1;
    time_src_i <= src;
    time_set_val_i <= '{16'h0800, ms};
    #1 was = local_ms_o;
    @(posedge core_clk_i);
    time_set_i <= 1'b0;
    #1 chk_val(48'(local_ms_o), 48'(src != rtbe_pkg::RTBE_SRC_NONE ? ms : was));
  endtask : step
  task automatic ld(input logic aid, input logic signed [7:0] l);
    @(posedge core_clk_i);
    leap_s_i <= l;
    utc_param_i <= ~aid;
    utc_param_aid_i <= aid;
    @(posedge core_clk_i);
    utc_param_i <= 1'b0;
    utc_param_aid_i <= 1'b0;
    lp = l;
    prm = 1'b1;
  endtask : ld
  task automatic sol(input logic [15:0] w, input logic [31:0] t,
                     input logic [19:0] s);
    rtbe_pkg::rtbe_utc_type e;
    int n;
    @(posedge core_clk_i);
    solution_i <= 1'b1;
    solved_time_i <= '{w, t};
    solved_sub_ns_i <= s;
    {nmea_compat_setting_i, utc_variant_select_i, date_known_i} <= 5'($random(seed));
    {glonass_base_i, confirm_avail_i, confirm_date_i} <= 3'($random(seed));
    {confirm_time_i, priority_nav_i, group_i} <= 4'($random(seed));
    @(posedge core_clk_i);
    solution_i <= 1'b0;
    e = exp_utc(w, t, s, lp);
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while (report_o !== 1'b1 && n < 300);
    nsol++;
    chk_utc(utc_o, e);
    chk_val(48'(gps_time_o), {w, t});
    chk_val(48'(epoch_gps_week_time_stamp_o), 48'(t));
    chk_val(48'(nmea_frac_o), 48'(nmea_compat_setting_i ? ecs * 10 : ecs));
    chk_val(48'(utc_variant_o), 48'(utc_variant_select_i));
    chk_val(48'(valid_o.time_known_flag), 48'(prm));
    chk_val(48'(valid_o.date_known_flag & ~date_known_i), 48'h0);
    chk_val(48'(valid_o.date_confirmed_flag & ~confirm_date_i), 48'h0);
    chk_val(48'(valid_o.confirmation_available_bit),
      48'(confirm_avail_i));
    chk_val(48'(valid_o.time_confirmed_flag & ~confirm_avail_i),
      48'h0);
    chk_val(48'(stamp_group_o),
      48'(priority_nav_i ? group_i : 2'h0));
    chk_val(48'(valid_o.whole_second_resolved_flag), 48'(prm | glonass_base_i));
  endtask : sol
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    seed = 32'hAB0E8857;
    {cyc, mismatches, num_checks, nsol, prm, lp} = '0;
    lp = 18;
    reset_i = 1'b1;
    {time_set_i, date_known_i, solution_i, utc_param_i, utc_param_aid_i} = '0;
    {glonass_base_i, confirm_avail_i, confirm_date_i, confirm_time_i} = '0;
    {priority_nav_i, nmea_compat_setting_i, group_i} = '0;
    utc_variant_select_i = 3'h0;
    leap_s_i = 8'sh12;
    solved_sub_ns_i = 20'h0;
    time_src_i = rtbe_pkg::RTBE_SRC_NONE;
    time_set_val_i = '0;
    solved_time_i = '0;
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'b0;
    repeat (203) @(posedge core_clk_i);
    #1 chk_val(48'(local_ms_o), 48'(ticks));
    chk_val(48'(epochs > 0), 48'h1);
    sol(16'd1669, 32'd16999, 20'd300000);
    step(rtbe_pkg::RTBE_SRC_SAT, 32'd5000);
    step(rtbe_pkg::RTBE_SRC_NONE, 32'd9000);
    step(rtbe_pkg::RTBE_SRC_AID, 32'd1000);
    sol(16'h0800, 32'd3000000, 20'd0);
    chk_val(48'(clock_bias_ms_o[31]), 48'h0);
    // Week 1669 opens the year, so this rounds across a year boundary
    ld(1'b0, 8'sd17);
    sol(16'd1669, 32'd16999, 20'd300000);
    sol(16'd1669, 32'd16999, 20'd94999);
    ld(1'b1, 8'sd19);
    repeat (12) sol(16'(1 + $unsigned($random(seed)) % 2400),
      $unsigned($random(seed)) % 604800000,
      20'($unsigned($random(seed)) % 1000000));
    repeat (2) @(posedge core_clk_i);
    #1 chk_val(48'(host_n), 48'(nsol));
    chk_val(48'(host_stamp), 48'(solved_time_i.tow_ms));
    final_report();
  end
endmodule : test_receiver_time_base_epoch
